/* File: design/tcr_regs.sv */
/*
 * Measurement setup register two, event flags, event enables and the
 * active-low interrupt pin of a time-to-digital converter.
 * Assumes the serial front end turns accesses into one-cycle write strobes
 * and combinational reads, and the measurement engine reports events as
 * one-cycle pulses on the same clock.
 */
// Contract
// - Cal window code picks 2/10/20/40 periods
// - Averaging cycles equal two to code
// - Stop codes 0-4 give 1-5 stops
// - Bit 4 set on completion, W1C
// - Bit 3 set on start, W1C
// - Reference overflow sets bit 2, halts
// - Ring overflow sets bit 1, halts
// - Bit 0 set on new result, W1C
// - Enable bits 2:0 reset to ones
// - Disabled source still sets its flag
// - Setup two at 01h resets 40h
// - Flags at 02h reset zero, top reserved
// - Launch bit write clears all flags
`timescale 1ns/100ps

module tcr_regs
    import tcr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Register access port
    input  wire logic [5:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    output logic      [7:0] reg_rdata_out,
    // Measurement engine events
    input  wire logic       meas_begun_in,
    input  wire logic       meas_done_in,
    input  wire logic       ref_overflow_in,
    input  wire logic       ring_overflow_in,
    // Decoded setup toward the engine
    output logic      [5:0] cal_window_length_out,
    output logic      [7:0] averaging_cycle_count_out,
    output logic      [2:0] stop_count_out,
    output logic            averaging_on_out,
    output logic            launch_out,
    output logic            halt_out,
    output logic      [7:0] coarse_limit_high_out,
    // Interrupt pin
    output logic            irq_n_pin_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] setup2_q;
    logic [7:0] setup2_d;
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [7:0] climh_q;
    logic [7:0] climh_d;
    logic       irq_n_q;
    logic       irq_n_d;
    logic [4:0] flags;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic       launch;
    logic       wr_flags;

    assign launch   = reg_write_in && (reg_addr_in == TCR_ADDR_LAUNCH)
                      && reg_wdata_in[TCR_BIT_LAUNCH];
    assign wr_flags = reg_write_in && (reg_addr_in == TCR_ADDR_FLAGS);

    // Writable registers; only implemented bits are kept
    always_comb
    begin
        setup2_d = setup2_q;
        enable_d = enable_q;
        climh_d  = climh_q;
        if (reg_write_in)
        begin
            case (reg_addr_in)
                TCR_ADDR_SETUP2: setup2_d = reg_wdata_in;
                TCR_ADDR_ENABLE: enable_d = reg_wdata_in & TCR_ENABLE_IMPL;
                TCR_ADDR_CLIMH:  climh_d  = reg_wdata_in;
                default:         setup2_d = setup2_q;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            setup2_q <= TCR_SETUP2_RST;
            enable_q <= TCR_ENABLE_RST;
            climh_q  <= TCR_CLIMH_RST;
        end
        else
        begin
            setup2_q <= setup2_d;
            enable_q <= enable_d;
            climh_q  <= climh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags; set sources are never masked
    assign flag_set[TCR_BIT_DONE]   = meas_done_in;
    assign flag_set[TCR_BIT_BEGUN]  = meas_begun_in;
    assign flag_set[TCR_BIT_REFOVF] = ref_overflow_in;
    assign flag_set[TCR_BIT_RNGOVF] = ring_overflow_in;
    assign flag_set[TCR_BIT_RESULT] = meas_done_in;

    // Write one clears; a launch clears every flag; zeros leave bits alone
    assign flag_clr = (wr_flags ? reg_wdata_in[4:0] : 5'h00)
                      | {5{launch}};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_flag
            tcr_flag_bit u_flag (
                .clk_in   (clk_in),
                .reset_in (reset_in),
                .set_in   (flag_set[gi]),
                .clear_in (flag_clr[gi]),
                .flag_out (flags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin, registered so it never glitches
    always_comb
    begin
        irq_n_d = ~|(flags[2:0] & enable_q[2:0]);
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            irq_n_q <= 1'b1;
        else
            irq_n_q <= irq_n_d;
    end

    assign irq_n_pin_out = irq_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved flag bits read zero
    always_comb
    begin
        case (reg_addr_in)
            TCR_ADDR_SETUP2: reg_rdata_out = setup2_q;
            TCR_ADDR_FLAGS:  reg_rdata_out = {3'h0, flags};
            TCR_ADDR_ENABLE: reg_rdata_out = enable_q;
            TCR_ADDR_CLIMH:  reg_rdata_out = climh_q;
            default:         reg_rdata_out = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode toward the engine
    always_comb
    begin
        case (setup2_q[TCR_CAL_LSB +: 2])
            2'h0:    cal_window_length_out = TCR_CAL_LEN0;
            2'h1:    cal_window_length_out = TCR_CAL_LEN1;
            2'h2:    cal_window_length_out = TCR_CAL_LEN2;
            default: cal_window_length_out = TCR_CAL_LEN3;
        endcase
    end

    // Count is 1 shifted by code, 1..128
    assign averaging_cycle_count_out = 8'h01 << setup2_q[TCR_AVG_LSB +: 3];
    assign averaging_on_out = |setup2_q[TCR_AVG_LSB +: 3];

    // Codes above four fall back to one stop, reported as count 1..5
    assign stop_count_out = (setup2_q[TCR_STOP_LSB +: 3] > TCR_STOP_MAX)
                            ? 3'h1 : 3'(setup2_q[TCR_STOP_LSB +: 3] + 3'h1);

    assign launch_out = launch;
    // Halt in the very cycle an overflow arrives
    assign halt_out = ref_overflow_in | ring_overflow_in;
    assign coarse_limit_high_out = climh_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_launch;
        launch && !(|flag_set);
    endsequence

    setup_reset_a: assert property (@(posedge clk_in)
        $fell(reset_in) |-> setup2_q == 8'h40)
        else $error("setup reset value wrong");
    enable_reset_a: assert property (@(posedge clk_in)
        $fell(reset_in) |-> enable_q == 8'h07)
        else $error("enable reset value wrong");
    // Flags and pin must come out of reset clean, whatever address is on the port
    flag_reset_a: assert property (@(posedge clk_in)
        $fell(reset_in) |-> flags == 5'h00 && irq_n_pin_out)
        else $error("flags not zero after reset");
    done_sets_a: assert property (@(posedge clk_in) disable iff (reset_in)
        meas_done_in |=> flags[4] && flags[0])
        else $error("done flags not set");
    begun_sets_a: assert property (@(posedge clk_in) disable iff (reset_in)
        meas_begun_in |=> flags[3])
        else $error("begun flag not set");
    ref_ovf_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ref_overflow_in |-> halt_out ##1 flags[2])
        else $error("reference overflow mishandled");
    ring_ovf_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ring_overflow_in |-> halt_out ##1 flags[1])
        else $error("ring overflow mishandled");
    result_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_flags && reg_wdata_in[0] && !meas_done_in |=> !flags[0])
        else $error("result flag not cleared");
    launch_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
        s_launch |=> flags == 5'h00)
        else $error("launch did not clear flags");
    masked_pin_a: assert property (@(posedge clk_in) disable iff (reset_in)
        enable_q[2:0] == 3'h0 |=> irq_n_pin_out)
        else $error("masked source drove pin");
    pin_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
        |(flags[2:0] & enable_q[2:0]) |=> !irq_n_pin_out)
        else $error("pin not asserted");
    cal_len_a: assert property (@(posedge clk_in) disable iff (reset_in)
        setup2_q[7:6] == 2'h3 |-> cal_window_length_out == 6'h28)
        else $error("cal window decode wrong");
    avg_max_a: assert property (@(posedge clk_in) disable iff (reset_in)
        setup2_q[5:3] == 3'h7 |-> averaging_cycle_count_out == 8'h80)
        else $error("averaging decode wrong");
    stop_fold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        setup2_q[2:0] > 3'h4 |-> stop_count_out == 3'h1)
        else $error("stop decode wrong");

endmodule

/* File: design/tcr_pkg.sv */
/*
 * Package for the measurement setup and event register bank.
 * Holds register indices, field positions, reset values and decode tables.
 * Assumes an 8-bit register access port with a 6-bit address.
 */
package tcr_pkg;

    // Register indices on the access port
    localparam logic [5:0] TCR_ADDR_LAUNCH = 6'h00;
    localparam logic [5:0] TCR_ADDR_SETUP2 = 6'h01;
    localparam logic [5:0] TCR_ADDR_FLAGS  = 6'h02;
    localparam logic [5:0] TCR_ADDR_ENABLE = 6'h03;
    localparam logic [5:0] TCR_ADDR_CLIMH  = 6'h04;

    // Reset values
    localparam logic [7:0] TCR_SETUP2_RST = 8'h40;
    localparam logic [7:0] TCR_FLAGS_RST  = 8'h00;
    localparam logic [7:0] TCR_ENABLE_RST = 8'h07;
    localparam logic [7:0] TCR_CLIMH_RST  = 8'hFF;

    // Field positions in the setup register
    localparam int TCR_CAL_LSB  = 6;
    localparam int TCR_AVG_LSB  = 3;
    localparam int TCR_STOP_LSB = 0;

    // Bit positions in the event flag register
    localparam int TCR_BIT_DONE   = 4;
    localparam int TCR_BIT_BEGUN  = 3;
    localparam int TCR_BIT_REFOVF = 2;
    localparam int TCR_BIT_RNGOVF = 1;
    localparam int TCR_BIT_RESULT = 0;

    // Launch bit position in the first configuration register
    localparam int TCR_BIT_LAUNCH = 0;

    // Implemented flag bits and interrupt enable bits
    localparam logic [7:0] TCR_FLAGS_IMPL  = 8'h1F;
    localparam logic [7:0] TCR_ENABLE_IMPL = 8'h07;

    // Calibration window lengths in reference periods
    localparam logic [5:0] TCR_CAL_LEN0 = 6'h02;
    localparam logic [5:0] TCR_CAL_LEN1 = 6'h0A;
    localparam logic [5:0] TCR_CAL_LEN2 = 6'h14;
    localparam logic [5:0] TCR_CAL_LEN3 = 6'h28;

    // Largest legal stop code
    localparam logic [2:0] TCR_STOP_MAX = 3'h4;

endpackage

/* File: design/tcr_flag_bit.sv */
/*
 * One sticky event flag with write-one-to-clear.
 * Assumes event and clear strobes are synchronous one-cycle levels.
 */
`timescale 1ns/100ps

module tcr_flag_bit
    import tcr_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Event and clear
    input  wire logic set_in,
    input  wire logic clear_in,
    // State
    output logic      flag_out
);

    logic flag_q;
    logic flag_d;

    ////////////////////////////////////////////////////////////////////////
    // Set wins over clear so an event in the clearing cycle is kept
    always_comb
    begin
        flag_d = flag_q;
        if (clear_in)
            flag_d = 1'b0;
        if (set_in)
            flag_d = 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign flag_out = flag_q;

    set_wins_a: assert property (@(posedge clk_in) disable iff (reset_in)
        set_in |=> flag_q)
        else $error("flag lost on set");

endmodule

/* File: verification/tcr_host_model.sv */
/*
 * Host side model: drives the register access port of the event bank.
 * Assumes one clock; requests change on falling edges and are taken on
 * the rising edge between them.
 */
`timescale 1ns/100ps

module tcr_host_model
(
    // Clock
    input  wire logic       clk_in,
    // Register access port
    output logic      [5:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            write_out,
    input  wire logic [7:0] rdata_in
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero, pointing at an unmapped index
    initial
    begin
        addr_out  = 6'h3F;
        wdata_out = 8'h00;
        write_out = 1'b0;
    end

    // One-cycle write strobe; data inverted once released so a stale
    // value can never look like a fresh write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out  = a;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge clk_in);
        write_out = 1'b0;
        wdata_out = ~d;
    endtask

    // Read data taken at the rising edge, address held until then
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        @(posedge clk_in);
        d = rdata_in;
    endtask
endmodule

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the setup, flag and enable registers.
 * Assumes the host model for register access; engine events are pulsed
 * here on falling edges.
 */
`timescale 1ns/100ps

module tb_top;
    import tcr_pkg::*;

    logic       clk_in   = 1'b0;
    logic       reset_in = 1'b1;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic [7:0] rdata;
    logic [3:0] ev       = 4'h0;
    logic [5:0] cal;
    logic [7:0] avg;
    logic [7:0] climh;
    logic [2:0] stops;
    logic       avg_on;
    logic       launch;
    logic       halt;
    logic       irq_n;
    logic       hl;
    logic [7:0] w;
    logic [2:0] c;
    logic [7:0] lens [4] = '{8'h02, 8'h0A, 8'h14, 8'h28};
    int         error_cnt = 0;
    int         checks    = 0;
    int         launches  = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and launch strobe counter
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (launch === 1'b1)
            launches++;

    tcr_host_model tcr_host_model_inst (
        .clk_in   (clk_in),
        .addr_out (addr),
        .wdata_out(wdata),
        .write_out(wr_en),
        .rdata_in (rdata)
    );

    tcr_regs tcr_regs_inst (
        .clk_in                   (clk_in),
        .reset_in                 (reset_in),
        .reg_addr_in              (addr),
        .reg_wdata_in             (wdata),
        .reg_write_in             (wr_en),
        .reg_rdata_out            (rdata),
        .meas_begun_in            (ev[0]),
        .meas_done_in             (ev[1]),
        .ref_overflow_in          (ev[2]),
        .ring_overflow_in         (ev[3]),
        .cal_window_length_out    (cal),
        .averaging_cycle_count_out(avg),
        .stop_count_out           (stops),
        .averaging_on_out         (avg_on),
        .launch_out               (launch),
        .halt_out                 (halt),
        .coarse_limit_high_out    (climh),
        .irq_n_pin_out            (irq_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare, read-compare, pin check and event pulse helpers
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        tcr_host_model_inst.rd(a, d);
        check(d, e);
    endtask

    // Pin is registered behind the flags, so look one edge later
    task automatic pin(input logic e);
        @(negedge clk_in);
        check({7'h0, irq_n}, {7'h0, e});
    endtask

    task automatic pulse(input logic [3:0] k);
        @(negedge clk_in);
        ev = k;
        #1 hl = halt;
        @(negedge clk_in);
        ev = 4'h0;
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: a hung sequence still reaches the verdict
    initial
    begin
        #200000;
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        rchk(6'h01, 8'h40);
        rchk(6'h02, 8'h00);
        rchk(6'h03, 8'h07);
        rchk(6'h04, 8'hFF);
        rchk(6'h3F, 8'h00);
        pin(1'b1);
        // Every code of all three setup fields
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            w = {c[1:0], c, c};
            tcr_host_model_inst.wr(TCR_ADDR_SETUP2, w);
            check({2'h0, cal}, lens[c[1:0]]);
            check(avg, 8'h01 << c);
            check({7'h0, avg_on}, {7'h0, c != 3'h0});
            check({5'h0, stops}, (c <= 3'h4) ? {5'h0, c} + 8'h01 : 8'h01);
            rchk(TCR_ADDR_SETUP2, w);
        end
        pulse(4'h1);
        check({7'h0, hl}, 8'h00);
        rchk(6'h02, 8'h08);
        pin(1'b1);
        tcr_host_model_inst.wr(6'h02, 8'h08);
        rchk(6'h02, 8'h00);
        pulse(4'h2);
        pin(1'b0);
        rchk(6'h02, 8'h11);
        tcr_host_model_inst.wr(6'h02, 8'h00);
        rchk(6'h02, 8'h11);
        tcr_host_model_inst.wr(6'h02, 8'h01);
        pin(1'b1);
        rchk(6'h02, 8'h10);
        tcr_host_model_inst.wr(6'h02, 8'h10);
        rchk(6'h02, 8'h00);
        pulse(4'h4);
        check({7'h0, hl}, 8'h01);
        pin(1'b0);
        rchk(6'h02, 8'h04);
        pulse(4'h8);
        check({7'h0, hl}, 8'h01);
        rchk(6'h02, 8'h06);
        tcr_host_model_inst.wr(6'h02, 8'h04);
        rchk(6'h02, 8'h02);
        pin(1'b0);
        tcr_host_model_inst.wr(6'h02, 8'hFF);
        rchk(6'h02, 8'h00);
        pin(1'b1);
        // Masked sources still flag; each enable alone drives the pin
        tcr_host_model_inst.wr(6'h03, 8'hFF);
        rchk(6'h03, 8'h07);
        tcr_host_model_inst.wr(6'h03, 8'h00);
        pulse(4'hE);
        pin(1'b1);
        rchk(6'h02, 8'h17);
        for (int j = 0; j < 3; j++)
        begin
            tcr_host_model_inst.wr(6'h03, 8'h01 << j);
            pin(1'b0);
        end
        tcr_host_model_inst.wr(TCR_ADDR_LAUNCH, 8'h01);
        check(launches[7:0], 8'h01);
        rchk(6'h02, 8'h00);
        pin(1'b1);
        tcr_host_model_inst.wr(6'h04, 8'hA5);
        check(climh, 8'hA5);
        rchk(6'h04, 8'hA5);
        // Leave flags set and the pin low so the reset has work to undo
        pulse(4'hE);
        pin(1'b0);
        // Second reset in mid-run restores every register
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        rchk(6'h04, 8'hFF);
        rchk(6'h03, 8'h07);
        rchk(6'h01, 8'h40);
        rchk(6'h02, 8'h00);
        pin(1'b1);
        final_report();
    end
endmodule
